// ===== emrps_top.sv
// mac reset, soft reset and pause sequencing with ahb-lite registers
`timescale 1ns/100ps
module emrps_top (
    input  wire logic                          SYS_CLK,
    input  wire logic                          RST,
    input  wire logic                          HSEL,
    input  wire logic [emrps_pkg::HADDR_W-1:0] HADDR,
    input  wire logic [1:0]                    HTRANS,
    input  wire logic                          HWRITE,
    input  wire logic [2:0]                    HSIZE,
    input  wire logic [3:0]                    HPROT,
    input  wire logic [emrps_pkg::HDATA_W-1:0] HWDATA,
    input  wire logic                          HREADY,
    output logic                               HREADYOUT,
    output logic                               HRESP,
    output logic      [emrps_pkg::HDATA_W-1:0] HRDATA,
    input  wire logic                          RX_CLK,
    input  wire logic                          RX_DV,
    output logic                               PHY_IF_SEL
);
    import emrps_pkg::*;

    typedef struct packed {
        logic             wr_pend;
        logic             wr_priv;
        logic [7:0]       wr_addr;
        logic [31:0]      rdata;
        logic             soft_reset_request_bit;
        logic [2:0]       swr_cnt;
        logic             krst_done;
        logic             lock;
        logic             if_sel;
        logic             tx_run;
        logic             rx_run;
        logic             rx_packet_flush_bit;
        logic             mac_rx;
        logic             mac_tx;
        logic             desc_err;
        logic [6:0]       settle;
        logic [7:0]       rx_pkts;
        logic [7:0]       tx_pkts;
        logic [LEN_W-1:0] tx_len;
        logic             tx_busy;
        logic [LEN_W-1:0] tx_timer;
        logic             tog_seen;
    } emrps_top_t;

    emrps_top_t s;
    emrps_top_t next_s;
    logic [1:0] link_raw;
    logic [1:0] link_s;
    logic       pkt_in;
    logic       rx_stopped;
    logic       link_rst;

    ////////////////////////////////////////////////////////////////////////
    // dma, queue and mac state back to idle; keeps lock and done flag
    function automatic emrps_top_t soft_clear(input emrps_top_t st);
        emrps_top_t r;
        r          = st;
        r.tx_run   = 1'b0;
        r.rx_run   = 1'b0;
        r.rx_packet_flush_bit      = 1'b0;
        r.mac_rx   = 1'b0;
        r.mac_tx   = 1'b0;
        r.desc_err = 1'b0;
        r.rx_pkts  = 8'h00;
        r.tx_pkts  = 8'h00;
        r.tx_len   = '0;
        r.tx_busy  = 1'b0;
        r.tx_timer = '0;
        r.settle   = RXQ_SETTLE_CYCLES;
        return r;
    endfunction

    function automatic logic [1:0] fill_of(input emrps_top_t st);
        logic [1:0] f;
        f = FILL_EMPTY;
        // queue contents are not trusted until the settle time expires
        if (st.settle != 7'd0) begin
            f = FILL_BELOW;
        end else if (st.rx_pkts == PKT_MAX) begin
            f = FILL_FULL;
        end else if (st.rx_pkts >= PKT_HALF) begin
            f = FILL_ABOVE;
        end else if (st.rx_pkts != 8'h00) begin
            f = FILL_BELOW;
        end
        return f;
    endfunction

    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                            input emrps_top_t st);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            ADDR_DMA_MODE:    w[BIT_SWR]        = st.soft_reset_request_bit;
            ADDR_KRST_REQ:    w[BIT_KRST_DONE]  = st.krst_done;
            ADDR_INIT_LOCK:   w[BIT_LOCK]       = st.lock;
            ADDR_IF_SEL:      w[BIT_IF_SEL]     = st.if_sel;
            ADDR_TX_DMA_CTRL: w[BIT_TX_DMA_RUN] = st.tx_run;
            ADDR_RX_DMA_CTRL: begin
                w[BIT_RX_DMA_RUN] = st.rx_run;
                w[BIT_RPF]        = st.rx_packet_flush_bit;
            end
            ADDR_MAC_CFG: begin
                w[BIT_MAC_RX_ON] = st.mac_rx;
                w[BIT_MAC_TX_ON] = st.mac_tx;
            end
            ADDR_DMA_STATUS: begin
                w[TPS_LSB +: 3] = st.desc_err ? PS_SUSPENDED :
                                  st.tx_run ? PS_RUNNING : PS_STOPPED;
                w[RPS_LSB +: 3] = st.desc_err ? PS_SUSPENDED :
                                  st.rx_run ? PS_RUNNING : PS_STOPPED;
                w[BIT_DESC_ERR] = st.desc_err;
            end
            ADDR_TXQ_DEBUG: begin
                w[TRCS_LSB +: 2] = st.tx_busy ? TRC_READ : TRC_IDLE;
                w[BIT_TXQ_NE]    = (st.tx_pkts != 8'h00);
            end
            ADDR_RXQ_DEBUG: begin
                w[RXQ_FILL_LSB +: 2] = fill_of(st);
                w[RX_PACKET_COUNT_LSB +: 8]     = st.rx_pkts;
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // link side: the phy receive clock may stop between frames
    emrps_rx_link u_link (
        .clk_link  (RX_CLK),
        .rx_dv     (RX_DV),
        .rx_on     (s.mac_rx),
        .rst_req   (link_rst),
        .frame_tog (link_raw[0]),
        .busy      (link_raw[1])
    );

    generate
        for (genvar i = 0; i < 2; i++) begin : g_back
            emrps_sync u_sync (
                .clk (SYS_CLK),
                .d   (link_raw[i]),
                .q   (link_s[i])
            );
        end
    endgenerate

    // held for the whole settle time so a slow link clock still sees it
    assign link_rst   = s.soft_reset_request_bit || (s.settle != 7'd0);
    assign pkt_in     = (link_s[0] != s.tog_seen) && (s.settle == 7'd0);
    assign rx_stopped = !s.mac_rx && !link_s[1];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s          = s;
        next_s.tog_seen = link_s[0];
        next_s.wr_pend  = 1'b0;

        if (s.settle != 7'd0) begin
            next_s.settle = s.settle - 7'd1;
        end

        // receive queue: arrivals, dma drain, flush
        if (s.rx_packet_flush_bit && rx_stopped) begin
            next_s.rx_pkts = 8'h00;
        end else begin
            unique case ({pkt_in && s.rx_pkts != PKT_MAX,
                          s.rx_run && s.rx_pkts != 8'h00})
                2'b10: next_s.rx_pkts = s.rx_pkts + 8'h01;
                2'b01: next_s.rx_pkts = s.rx_pkts - 8'h01;
                2'b00, 2'b11: next_s.rx_pkts = s.rx_pkts;
            endcase
        end

        // transmit engine drains queued frames only while mac tx is on
        if (s.tx_busy) begin
            next_s.tx_timer = s.tx_timer - 14'd1;
            if (s.tx_timer == 14'd0) begin
                next_s.tx_busy = 1'b0;
            end
        end else if (s.tx_pkts != 8'h00 && s.mac_tx) begin
            next_s.tx_busy  = 1'b1;
            next_s.tx_timer = s.tx_len;
            next_s.tx_pkts  = s.tx_pkts - 8'h01;
        end

        // soft reset runs for a fixed count, then the bit drops
        if (s.soft_reset_request_bit) begin
            next_s.swr_cnt = s.swr_cnt + 3'd1;
            if (s.swr_cnt == SWR_CYCLES - 3'd1) begin
                next_s     = soft_clear(next_s);
                next_s.soft_reset_request_bit = 1'b0;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // bus write data phase
        if (s.wr_pend) begin
            case (s.wr_addr)
                ADDR_DMA_MODE: begin
                    if (HWDATA[BIT_SWR] && !s.soft_reset_request_bit) begin
                        next_s.soft_reset_request_bit     = 1'b1;
                        next_s.swr_cnt = 3'd1;
                    end
                end
                ADDR_KRST_REQ: begin
                    if (s.wr_priv && !s.lock && HWDATA[BIT_KRST_REQ]) begin
                        next_s           = soft_clear(next_s);
                        next_s.if_sel    = RST_IF_SEL;
                        next_s.soft_reset_request_bit       = 1'b0;
                        next_s.krst_done = 1'b1;
                    end
                end
                ADDR_KRST_CLR: begin
                    // the done flag has no other setter in this cycle
                    if (s.wr_priv && !s.lock && HWDATA[BIT_KRST_CLR]) begin
                        next_s.krst_done = 1'b0;
                    end
                end
                ADDR_INIT_LOCK: next_s.lock = HWDATA[BIT_LOCK];
                ADDR_IF_SEL: next_s.if_sel = HWDATA[BIT_IF_SEL];
                ADDR_TX_DMA_CTRL: begin
                    next_s.tx_run = HWDATA[BIT_TX_DMA_RUN];
                end
                ADDR_RX_DMA_CTRL: begin
                    next_s.rx_run = HWDATA[BIT_RX_DMA_RUN];
                    next_s.rx_packet_flush_bit    = HWDATA[BIT_RPF];
                end
                ADDR_MAC_CFG: begin
                    next_s.mac_rx = HWDATA[BIT_MAC_RX_ON];
                    next_s.mac_tx = HWDATA[BIT_MAC_TX_ON];
                end
                ADDR_TX_DESC3: begin
                    // a descriptor is only fetched while tx dma runs
                    if (s.tx_run && HWDATA[BIT_LAST_DESC]) begin
                        if (HWDATA[LEN_LSB +: LEN_W] == 14'd0) begin
                            next_s.desc_err = 1'b1;
                            next_s.tx_run   = 1'b0;
                            next_s.rx_run   = 1'b0;
                        end else if (next_s.tx_pkts != PKT_MAX) begin
                            next_s.tx_pkts = next_s.tx_pkts + 8'h01;
                            next_s.tx_len  = HWDATA[LEN_LSB +: LEN_W];
                        end
                    end
                end
                default: next_s.wr_pend = 1'b0;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // bus address phase; read data taken from the updated state
        if (HSEL && HREADY && HTRANS[1]) begin
            next_s.wr_pend = HWRITE;
            next_s.wr_priv = HPROT[1];
            next_s.wr_addr = HADDR[7:0];
            next_s.rdata   = HWRITE ? 32'h0000_0000
                                    : rd_word(HADDR[7:0], next_s);
        end

        if (RST) begin
            next_s           = '0;
            next_s.lock      = RST_LOCK;
            next_s.if_sel    = RST_IF_SEL;
            next_s.settle    = RXQ_SETTLE_CYCLES;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////
    assign HREADYOUT  = 1'b1;
    assign HRESP      = 1'b0;
    assign HRDATA     = s.rdata;
    assign PHY_IF_SEL = s.if_sel;
endmodule // emrps_top

// ===== emrps_pkg.sv
// constants for the mac reset and pause sequencing block
// How it works
// - kernel reset writes need supervisor, unlocked
// - soft reset bit self clears within 4 cycles
// - receiver stops in 3 sys plus 6 link
// - flush bit discards queued packets after stop
package emrps_pkg;
    localparam int          HDATA_W           = 32;
    localparam int          HADDR_W           = 32;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0]  ADDR_DMA_MODE     = 8'h00;
    localparam logic [7:0]  ADDR_KRST_REQ     = 8'h04;
    localparam logic [7:0]  ADDR_KRST_CLR     = 8'h08;
    localparam logic [7:0]  ADDR_INIT_LOCK    = 8'h0C;
    localparam logic [7:0]  ADDR_IF_SEL       = 8'h10;
    localparam logic [7:0]  ADDR_TX_DMA_CTRL  = 8'h14;
    localparam logic [7:0]  ADDR_RX_DMA_CTRL  = 8'h18;
    localparam logic [7:0]  ADDR_MAC_CFG      = 8'h1C;
    localparam logic [7:0]  ADDR_DMA_STATUS   = 8'h20;
    localparam logic [7:0]  ADDR_TXQ_DEBUG    = 8'h24;
    localparam logic [7:0]  ADDR_RXQ_DEBUG    = 8'h28;
    localparam logic [7:0]  ADDR_TX_DESC3     = 8'h2C;
    ////////////////////////////////////////////////////////////////////////
    localparam int          BIT_SWR           = 0;
    localparam int          BIT_KRST_REQ      = 0;
    localparam int          BIT_KRST_DONE     = 1;
    localparam int          BIT_KRST_CLR      = 0;
    localparam int          BIT_LOCK          = 0;
    localparam int          BIT_IF_SEL        = 0;
    localparam int          BIT_TX_DMA_RUN    = 0;
    localparam int          BIT_RX_DMA_RUN    = 0;
    localparam int          BIT_RPF           = 1;
    localparam int          BIT_MAC_RX_ON     = 0;
    localparam int          BIT_MAC_TX_ON     = 1;
    localparam int          BIT_LAST_DESC     = 28;
    localparam int          LEN_LSB           = 0;
    localparam int          LEN_W             = 14;
    localparam int          TPS_LSB           = 0;
    localparam int          RPS_LSB           = 4;
    localparam int          BIT_DESC_ERR      = 8;
    localparam int          TRCS_LSB          = 1;
    localparam int          BIT_TXQ_NE        = 4;
    localparam int          RXQ_FILL_LSB      = 4;
    localparam int          RX_PACKET_COUNT_LSB          = 16;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [2:0]  PS_STOPPED        = 3'h0;
    localparam logic [2:0]  PS_RUNNING        = 3'h3;
    localparam logic [2:0]  PS_SUSPENDED      = 3'h4;
    localparam logic [1:0]  TRC_IDLE          = 2'h0;
    localparam logic [1:0]  TRC_READ          = 2'h1;
    localparam logic [1:0]  FILL_EMPTY        = 2'h0;
    localparam logic [1:0]  FILL_BELOW        = 2'h1;
    localparam logic [1:0]  FILL_ABOVE        = 2'h2;
    localparam logic [1:0]  FILL_FULL         = 2'h3;
    localparam logic [7:0]  PKT_MAX           = 8'hFF;
    localparam logic [7:0]  PKT_HALF          = 8'h80;
    ////////////////////////////////////////////////////////////////////////
    localparam logic        RST_LOCK          = 1'b1;
    localparam logic        RST_IF_SEL        = 1'b0;
    localparam logic [6:0]  RXQ_SETTLE_CYCLES = 7'd70;
    localparam logic [2:0]  SWR_CYCLES        = 3'd4;
endpackage

// ===== emrps_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/100ps
module emrps_sync (
    input  wire logic clk,
    input  wire logic d,
    output logic      q
);
    import emrps_pkg::*;

    typedef struct packed {
        logic meta;
        logic stable;
    } emrps_sync_t;

    emrps_sync_t s;
    emrps_sync_t next_s;

    // meta feeds only the second stage
    always_comb begin
        next_s.meta   = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    assign q = s.stable;
endmodule // emrps_sync

// ===== emrps_rx_link.sv
// receive framing on the phy receive clock
`timescale 1ns/100ps
module emrps_rx_link (
    input  wire logic clk_link,
    input  wire logic rx_dv,
    input  wire logic rx_on,
    input  wire logic rst_req,
    output logic      frame_tog,
    output logic      busy
);
    import emrps_pkg::*;

    typedef struct packed {
        logic dv_q;
        logic in_frame;
        logic tog;
    } emrps_link_t;

    emrps_link_t s;
    emrps_link_t next_s;
    logic        rx_on_s;
    logic        rst_s;

    emrps_sync u_on  (.clk(clk_link), .d(rx_on),   .q(rx_on_s));
    emrps_sync u_rst (.clk(clk_link), .d(rst_req), .q(rst_s));

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s      = s;
        next_s.dv_q = rx_dv;
        if (rst_s) begin
            next_s = '0;
        end else if (!s.in_frame) begin
            // frames only start on a clean rising valid edge
            if (rx_dv && !s.dv_q && rx_on_s) begin
                next_s.in_frame = 1'b1;
            end
        end else if (!rx_dv) begin
            next_s.in_frame = 1'b0;
            next_s.tog      = ~s.tog;
        end
    end

    always_ff @(posedge clk_link) begin
        s <= next_s;
    end

    assign frame_tog = s.tog;
    assign busy      = s.in_frame;
endmodule // emrps_rx_link

// ===== emrps_properties.sv
// checker of bus replies, soft reset, kernel reset flag and flush
`timescale 1ns/100ps
module emrps_checker (
    input wire logic                          SYS_CLK,
    input wire logic                          RST,
    input wire logic                          HSEL,
    input wire logic [emrps_pkg::HADDR_W-1:0] HADDR,
    input wire logic [1:0]                    HTRANS,
    input wire logic                          HWRITE,
    input wire logic [2:0]                    HSIZE,
    input wire logic [3:0]                    HPROT,
    input wire logic [emrps_pkg::HDATA_W-1:0] HWDATA,
    input wire logic                          HREADY,
    input wire logic                          HREADYOUT,
    input wire logic                          HRESP,
    input wire logic [emrps_pkg::HDATA_W-1:0] HRDATA,
    input wire logic                          RX_CLK,
    input wire logic                          RX_DV,
    input wire logic                          PHY_IF_SEL
);
    import emrps_pkg::*;
    typedef struct packed {
        logic       dp_on;
        logic       dp_wr;
        logic       dp_priv;
        logic [7:0] dp_addr;
        logic       lock;
        logic       clr_seen;
        logic       flush;
        logic       rx_on;
        logic [3:0] swr_age;
        logic [4:0] fl_cnt;
    } emrps_chk_t;
    emrps_chk_t st;
    emrps_chk_t next_st;
    logic       wr_end;
    logic       rd_end;
    logic       kr_ok;
    assign wr_end = st.dp_on && st.dp_wr && HREADY;
    assign rd_end = st.dp_on && !st.dp_wr && HREADY;
    assign kr_ok  = st.dp_priv && !st.lock && HWDATA[0];
    ////////////////////////////////////////////////////////////////////////
    // shadows err towards silence: any reset-like write drops flush
    always_comb begin
        next_st = st;
        if (HREADY) begin
            next_st.dp_on   = HSEL && HTRANS[1];
            next_st.dp_wr   = HWRITE;
            next_st.dp_priv = HPROT[1];
            next_st.dp_addr = HADDR[7:0];
        end
        if (st.swr_age != 4'hF)
            next_st.swr_age = st.swr_age + 4'h1;
        if (wr_end) begin
            case (st.dp_addr)
                ADDR_INIT_LOCK:   next_st.lock = HWDATA[BIT_LOCK];
                ADDR_RX_DMA_CTRL: next_st.flush = HWDATA[BIT_RPF];
                ADDR_MAC_CFG:     next_st.rx_on = HWDATA[BIT_MAC_RX_ON];
                ADDR_TX_DESC3:    next_st.flush = 1'b0;
                ADDR_KRST_CLR: begin
                    if (kr_ok)
                        next_st.clr_seen = 1'b1;
                end
                ADDR_KRST_REQ: begin
                    if (kr_ok) begin
                        next_st.clr_seen = 1'b0;
                        next_st.flush    = 1'b0;
                    end
                end
                ADDR_DMA_MODE: begin
                    next_st.swr_age = 4'h0;
                    next_st.flush   = 1'b0;
                end
                default: ;
            endcase
        end
        if (next_st.flush && !next_st.rx_on && !RX_DV) begin
            if (st.fl_cnt != 5'h1F)
                next_st.fl_cnt = st.fl_cnt + 5'h01;
        end else begin
            next_st.fl_cnt = 5'h00;
        end
        if (RST) begin
            next_st         = '0;
            next_st.lock    = RST_LOCK;
            next_st.swr_age = 4'hF;
        end
    end
    always_ff @(posedge SYS_CLK) begin
        st <= next_st;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus reply not ready or not okay");
    a_rdata_hold: assert property
        (!(HSEL && HTRANS[1] && HREADY) |=> $stable(HRDATA))
        else $error("read data moved without a transfer");
    a_swr_self_clear: assert property (
        rd_end && st.dp_addr == ADDR_DMA_MODE && st.swr_age >= 4'h4
        |-> HRDATA[BIT_SWR] == 1'b0)
        else $error("soft reset bit still set after four cycles");
    a_krst_flag_clear: assert property (
        rd_end && st.dp_addr == ADDR_KRST_REQ && st.clr_seen
        |-> !HRDATA[BIT_KRST_DONE])
        else $error("reset done flag set without a granted request");
    a_flush_empties: assert property (
        rd_end && st.dp_addr == ADDR_RXQ_DEBUG && st.fl_cnt >= 5'h10
        |-> HRDATA[23:16] == 8'h00)
        else $error("flushed queue still holds packets");
    a_unmapped_zero: assert property (
        rd_end && st.dp_addr >= 8'h30 |-> HRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    c_krst_done: cover property
        (rd_end && st.dp_addr == ADDR_KRST_REQ && HRDATA[BIT_KRST_DONE]);
    c_flush_held: cover property (st.fl_cnt == 5'h10);
    c_swr_read: cover property (rd_end && st.dp_addr == ADDR_DMA_MODE);
endmodule // emrps_checker
bind emrps_top emrps_checker emrps_checker_inst (
    .SYS_CLK(SYS_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HPROT(HPROT),
    .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .HRDATA(HRDATA), .RX_CLK(RX_CLK), .RX_DV(RX_DV),
    .PHY_IF_SEL(PHY_IF_SEL));

// ===== emrps_phy_model.sv
// phy receive side model: link clock and framed data valid
`timescale 1ns/100ps
module emrps_phy_model (
    input  wire logic clk_en,
    output logic      rx_clk,
    output logic      rx_dv
);
    logic in_frame;
    // clock stands low between frames unless held running around resets
    initial begin
        rx_clk   = 1'b0;
        rx_dv    = 1'b0;
        in_frame = 1'b0;
        #3.3;
        forever begin
            #6;
            if (clk_en || in_frame)
                rx_clk = ~rx_clk;
            else
                rx_clk = 1'b0;
        end
    end
    // six idle clocks first so the receiver can see an enable change
    task automatic send_frame(input int n);
        in_frame = 1'b1;
        repeat (6) @(posedge rx_clk);
        rx_dv <= 1'b1;
        repeat (n) @(posedge rx_clk);
        rx_dv <= 1'b0;
        repeat (6) @(posedge rx_clk);
        in_frame = 1'b0;
    endtask
endmodule // emrps_phy_model

// ===== tb_emrps_top.sv
// self-checking bench for the reset and pause sequencing block
`timescale 1ns/100ps
module tb_emrps_top;
    import emrps_pkg::*;
    logic        SYS_CLK;
    logic        RST;
    logic        HSEL;
    logic        HWRITE;
    logic        HREADYOUT;
    logic        HRESP;
    logic        RX_CLK;
    logic        RX_DV;
    logic        PHY_IF_SEL;
    logic        clk_en;
    logic [31:0] HADDR;
    logic [31:0] HWDATA;
    logic [31:0] HRDATA;
    logic [31:0] rd;
    logic [1:0]  HTRANS;
    logic [3:0]  HPROT;
    int          bad_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    emrps_top emrps_top_inst (
        .SYS_CLK(SYS_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HPROT(HPROT),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .HRDATA(HRDATA), .RX_CLK(RX_CLK), .RX_DV(RX_DV),
        .PHY_IF_SEL(PHY_IF_SEL));
    emrps_phy_model emrps_phy_model_inst (
        .clk_en(clk_en), .rx_clk(RX_CLK), .rx_dv(RX_DV));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    // entered just after a rising edge, leaves at the edge ending data
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic p);
        HSEL   <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= w;
        HADDR  <= {24'h00_0000, a};
        HPROT  <= {2'b00, p, 1'b1};
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
        HSEL   <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= w ? d : 32'h0000_0000;
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
        rd = HRDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b1);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000, 1'b1);
        chk(rd & m, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        RST    = 1'b1;
        HSEL   = 1'b0;
        HTRANS = 2'b00;
        HWRITE = 1'b0;
        HPROT  = 4'h0;
        HADDR  = 32'h0000_0000;
        HWDATA = 32'h0000_0000;
        clk_en = 1'b1;
        idle(10);
        RST <= 1'b0;
        idle(1);
        rchk(ADDR_RXQ_DEBUG, 32'h0000_0030, 32'h0000_0010);
        rchk(ADDR_INIT_LOCK, 32'hFFFF_FFFF, 32'h0000_0001);
        rchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        // power-on path: interface select then soft reset only
        wr(ADDR_IF_SEL, 32'h0000_0001);
        wr(ADDR_DMA_MODE, 32'h0000_0001);
        idle(4);
        rchk(ADDR_DMA_MODE, 32'hFFFF_FFFF, 32'h0000_0000);
        chk({31'h0000_0000, PHY_IF_SEL}, 32'h0000_0001);
        // kernel reset by privilege and lock; no irq to mask
        wr(ADDR_INIT_LOCK, 32'h0000_0000);
        wr(ADDR_KRST_CLR, 32'h0000_0001);
        wr(ADDR_INIT_LOCK, 32'h0000_0001);
        wr(ADDR_KRST_REQ, 32'h0000_0001);
        rchk(ADDR_KRST_REQ, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(ADDR_INIT_LOCK, 32'h0000_0000);
        rchk(ADDR_DMA_STATUS, 32'h0000_0177, 32'h0000_0000);
        rchk(ADDR_TXQ_DEBUG, 32'hFFFF_FFFF, 32'h0000_0000);
        xfer(1'b1, ADDR_KRST_REQ, 32'h0000_0001, 1'b0);
        rchk(ADDR_KRST_REQ, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(ADDR_KRST_REQ, 32'h0000_0001);
        idle(10);
        rchk(ADDR_KRST_REQ, 32'h0000_0002, 32'h0000_0002);
        chk({31'h0000_0000, PHY_IF_SEL}, 32'h0000_0000);
        wr(ADDR_IF_SEL, 32'h0000_0001);
        wr(ADDR_KRST_CLR, 32'h0000_0001);
        rchk(ADDR_KRST_REQ, 32'h0000_0002, 32'h0000_0000);
        wr(ADDR_INIT_LOCK, 32'h0000_0001);
        idle(80);
        clk_en <= 1'b0;
        rchk(ADDR_RXQ_DEBUG, 32'h00FF_0030, 32'h0000_0000);
        // receive traffic, receiver off, flush, drain
        wr(ADDR_MAC_CFG, 32'h0000_0003);
        emrps_phy_model_inst.send_frame(8);
        emrps_phy_model_inst.send_frame(3);
        idle(12);
        rchk(ADDR_RXQ_DEBUG, 32'h00FF_0030, 32'h0002_0010);
        wr(ADDR_MAC_CFG, 32'h0000_0002);
        rchk(ADDR_MAC_CFG, 32'h0000_0003, 32'h0000_0002);
        idle(3);
        emrps_phy_model_inst.send_frame(5);
        idle(12);
        rchk(ADDR_RXQ_DEBUG, 32'h00FF_0030, 32'h0002_0010);
        wr(ADDR_RX_DMA_CTRL, 32'h0000_0002);
        idle(20);
        rchk(ADDR_RXQ_DEBUG, 32'h00FF_0030, 32'h0000_0000);
        wr(ADDR_RX_DMA_CTRL, 32'h0000_0000);
        wr(ADDR_MAC_CFG, 32'h0000_0003);
        emrps_phy_model_inst.send_frame(4);
        idle(12);
        rchk(ADDR_RXQ_DEBUG, 32'h00FF_0030, 32'h0001_0010);
        wr(ADDR_RX_DMA_CTRL, 32'h0000_0001);
        idle(4);
        rchk(ADDR_RXQ_DEBUG, 32'h00FF_0030, 32'h0000_0000);
        // transmit: a good frame, then a zero-length last descriptor
        wr(ADDR_TX_DMA_CTRL, 32'h0000_0001);
        wr(ADDR_TX_DESC3, 32'h1000_0010);
        rchk(ADDR_TXQ_DEBUG, 32'h0000_0016, 32'h0000_0002);
        wr(ADDR_TX_DMA_CTRL, 32'h0000_0000);
        idle(40);
        rchk(ADDR_TXQ_DEBUG, 32'h0000_0016, 32'h0000_0000);
        rchk(ADDR_TX_DMA_CTRL, 32'h0000_0001, 32'h0000_0000);
        wr(ADDR_TX_DMA_CTRL, 32'h0000_0001);
        wr(ADDR_TX_DESC3, 32'h1000_0000);
        idle(4);
        rchk(ADDR_DMA_STATUS, 32'h0000_0177, 32'h0000_0144);
        rchk(ADDR_TX_DMA_CTRL, 32'h0000_0001, 32'h0000_0000);
        rchk(ADDR_RX_DMA_CTRL, 32'h0000_0001, 32'h0000_0000);
        end_sim();
    end
endmodule // tb_emrps_top
